// ===== core/usp_pkg.sv
// Constants, register map and types of the serial port block
package usp_pkg;
    localparam int AW = 12;
    localparam int IW = AW - 2;
    // Register indices; byte address is four times the index
    localparam logic [IW-1:0] IDX_SERIAL_CONTROL = 10'h098;
    localparam logic [IW-1:0] IDX_SERIAL_BUFFER = 10'h099;
    localparam logic [IW-1:0] IDX_FRAC = 10'h09D;
    localparam logic [IW-1:0] IDX_INTDIV = 10'h09E;
    localparam logic [IW-1:0] IDX_BSRC = 10'h09F;
    localparam logic [IW-1:0] IDX_CFG = 10'h0A0;
    localparam logic [IW-1:0] IDX_IST = 10'h0A1;
    localparam logic [IW-1:0] IDX_IMASK = 10'h0A2;
    // Field positions and write masks
    localparam int FRAC_EN_BIT = 7;
    localparam int FRAC_W = 6;
    localparam logic [7:0] FRAC_MASK = 8'hBF;
    localparam int BSRC_BAUD_DOUBLER_BIT = 7;
    localparam int BSRC_RCLK_BIT = 5;
    localparam int BSRC_TX_CLOCK_FROM_TIMER2_BIT = 4;
    localparam logic [7:0] BSRC_MASK = 8'hB0;
    localparam int CFG_OWE_BIT = 7;
    localparam int CFG_FE_BIT = 6;
    localparam int CFG_EXT_BIT = 0;
    localparam int IST_W = 3;
    localparam logic [7:0] REG_RST = 8'h00;
    // Bit timing: async mode in ticks, shift mode in clock cycles
    localparam logic [3:0] M0_LAST = 4'hB;
    localparam logic [3:0] M0_HALF = 4'h6;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic mode_select_hi;
        logic mode_select_lo;
        logic frame_check_enable;
        logic rx_enable;
        logic tx_ninth_bit;
        logic received_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } usp_serial_control_t;

    typedef enum logic [1:0] {
        MODE_SHIFT = 2'h0,
        MODE_ASYNC8 = 2'h1,
        MODE_FIXED9 = 2'h2,
        MODE_VAR9 = 2'h3
    } usp_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_START = 2'h1,
        ST_DATA = 2'h3,
        ST_STOP = 2'h2
    } usp_state_t;
endpackage

// ===== core/usp_serial_port.sv
// Serial port: shift register mode, 8-bit async mode, baud timer, AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module usp_serial_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [usp_pkg::AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [usp_pkg::AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe_n,
    output logic txd,
    output logic irq
);
    import usp_pkg::*;

    usp_serial_control_t serial_control_ff;
    logic [7:0] frac_ff, intdiv_ff, bsrc_ff, rxbuf_ff, wbyte_ff;
    logic extended_uart_enable_ff, owe_ff, fe_ff, wlane_ff, irq_ff;
    logic [IST_W-1:0] ist_ff, imask_ff;
    logic aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [AW-1:0] aw_addr_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic wr_fire;
    logic [IW-1:0] wr_idx, rd_idx;
    logic [7:0] rd_mux;

    function automatic logic mapped(input logic [IW-1:0] idx);
        mapped = idx inside {IDX_SERIAL_CONTROL, IDX_SERIAL_BUFFER, IDX_FRAC, IDX_INTDIV, IDX_BSRC,
                             IDX_CFG, IDX_IST, IDX_IMASK};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; one write and one read at a time
    assign wr_fire = aw_full_ff & w_full_ff & ~bvalid_ff;
    assign wr_idx = aw_addr_ff[AW-1:2];
    assign rd_idx = araddr[AW-1:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            aw_addr_ff <= '0;
            wbyte_ff <= REG_RST;
            wlane_ff <= 1'b0;
        end else begin
            if (awvalid && awready_ff) begin
                aw_addr_ff <= awaddr;
                aw_full_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (wvalid && wready_ff) begin
                wbyte_ff <= wdata[7:0];
                wlane_ff <= wstrb[0];
                w_full_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
                aw_full_ff <= 1'b0;
                w_full_ff <= 1'b0;
            end
            if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    always_comb begin
        unique case (rd_idx)
            IDX_SERIAL_CONTROL: rd_mux = serial_control_ff;
            IDX_SERIAL_BUFFER: rd_mux = rxbuf_ff;
            IDX_FRAC: rd_mux = frac_ff;
            IDX_INTDIV: rd_mux = intdiv_ff;
            IDX_BSRC: rd_mux = bsrc_ff;
            IDX_CFG: rd_mux = {owe_ff, fe_ff, 5'h00, extended_uart_enable_ff};
            IDX_IST: rd_mux = {5'h00, ist_ff};
            IDX_IMASK: rd_mux = {5'h00, imask_ff};
            default: rd_mux = REG_RST;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h00_0000, rd_mux};
            rresp_ff <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    logic wr_ok, wr_serial_control, wr_serial_buffer, wr_frac, wr_intdiv, wr_bsrc, wr_cfg, wr_ist, wr_imask;
    assign wr_ok = wr_fire & wlane_ff;
    assign wr_serial_control = wr_ok & (wr_idx == IDX_SERIAL_CONTROL);
    assign wr_serial_buffer = wr_ok & (wr_idx == IDX_SERIAL_BUFFER);
    assign wr_frac = wr_ok & (wr_idx == IDX_FRAC);
    assign wr_intdiv = wr_ok & (wr_idx == IDX_INTDIV);
    assign wr_bsrc = wr_ok & (wr_idx == IDX_BSRC);
    assign wr_cfg = wr_ok & (wr_idx == IDX_CFG);
    assign wr_ist = wr_ok & (wr_idx == IDX_IST);
    assign wr_imask = wr_ok & (wr_idx == IDX_IMASK);

    ////////////////////////////////////////////////////////////////////////////
    // Baud sources
    logic baud_en, baud_doubler, tx_clock_from_timer2, rclk, ut_tick, t1_tick, tx_tick, rx_tick, ut_carry;
    logic [7:0] ut_cnt_ff;
    logic [5:0] ut_acc_ff, ut_sum;
    logic t1_half_ff;
    usp_mode_t mode;
    assign baud_en = frac_ff[FRAC_EN_BIT];
    assign baud_doubler = bsrc_ff[BSRC_BAUD_DOUBLER_BIT];
    assign tx_clock_from_timer2 = bsrc_ff[BSRC_TX_CLOCK_FROM_TIMER2_BIT];
    assign rclk = bsrc_ff[BSRC_RCLK_BIT];
    assign mode = usp_mode_t'({serial_control_ff.mode_select_hi, serial_control_ff.mode_select_lo});
    assign {ut_carry, ut_sum} = {1'b0, ut_acc_ff} + {1'b0, frac_ff[FRAC_W-1:0]};
    assign ut_tick = baud_en & (ut_cnt_ff == 8'h00);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frac_ff <= REG_RST;
            intdiv_ff <= REG_RST;
            bsrc_ff <= REG_RST;
        end else begin
            if (wr_frac) frac_ff <= wbyte_ff & FRAC_MASK;
            if (wr_intdiv) intdiv_ff <= wbyte_ff;
            if (wr_bsrc) bsrc_ff <= wbyte_ff & BSRC_MASK;
        end
    end

    // Fraction stretches a tick period by one cycle on each accumulator carry
    always_ff @(posedge aclk) begin
        if (!aresetn || !baud_en) begin
            ut_cnt_ff <= intdiv_ff;
            ut_acc_ff <= '0;
        end else if (ut_cnt_ff == 8'h00) begin
            ut_acc_ff <= ut_sum;
            ut_cnt_ff <= intdiv_ff + {7'h00, ut_carry};
        end else begin
            ut_cnt_ff <= ut_cnt_ff - 8'h01;
        end
    end

    // Timer1 needs 32 overflows per bit unless doubled
    always_ff @(posedge aclk) begin
        if (!aresetn) t1_half_ff <= 1'b0;
        else if (timer1_ovf) t1_half_ff <= ~t1_half_ff;
    end
    assign t1_tick = timer1_ovf & (baud_doubler | t1_half_ff);
    assign tx_tick = baud_en ? ut_tick : (tx_clock_from_timer2 ? timer2_ovf : t1_tick);
    assign rx_tick = baud_en ? ut_tick : (rclk ? timer2_ovf : t1_tick);

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter
    usp_state_t tx_st_ff, rx_st_ff;
    logic [3:0] tx_cnt_ff, rx_cnt_ff;
    logic [2:0] tx_bit_ff, rx_bit_ff;
    logic [8:0] tx_sh_ff;
    logic [7:0] rx_sh_ff;
    logic tx_m0_ff, rx_m0_ff, tx_end, tx_go, tx_done_set, tx_fin_ff;
    assign tx_end = (tx_m0_ff | tx_tick) & (tx_cnt_ff == (tx_m0_ff ? M0_LAST : OVS_LAST));
    assign tx_go = wr_serial_buffer & (tx_st_ff == ST_IDLE)
                   & ((mode == MODE_ASYNC8) | ((mode == MODE_SHIFT) & (rx_st_ff == ST_IDLE)));
    assign tx_done_set = (tx_st_ff == ST_DATA) & tx_end & (tx_bit_ff == BIT_LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_st_ff <= ST_IDLE;
            tx_cnt_ff <= '0;
            tx_bit_ff <= '0;
            tx_sh_ff <= '1;
            tx_m0_ff <= 1'b0;
            tx_fin_ff <= 1'b0;
        end else begin
            tx_fin_ff <= tx_done_set;
            if (tx_st_ff != ST_IDLE && (tx_m0_ff || tx_tick)) tx_cnt_ff <= tx_cnt_ff + 4'h1;
            unique case (tx_st_ff)
                ST_IDLE: begin
                    if (tx_go) begin
                        tx_sh_ff <= {1'b1, wbyte_ff};
                        tx_m0_ff <= (mode == MODE_SHIFT);
                        tx_st_ff <= (mode == MODE_SHIFT) ? ST_DATA : ST_START;
                        tx_cnt_ff <= '0;
                        tx_bit_ff <= '0;
                    end
                end
                ST_START: begin
                    if (tx_end) begin
                        tx_cnt_ff <= '0;
                        tx_st_ff <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tx_end) begin
                        tx_cnt_ff <= '0;
                        tx_sh_ff <= {1'b1, tx_sh_ff[8:1]};
                        tx_bit_ff <= tx_bit_ff + 3'h1;
                        if (tx_bit_ff == BIT_LAST) tx_st_ff <= tx_m0_ff ? ST_IDLE : ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tx_end) tx_st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver
    logic rxd_s1_ff, rxd_s2_ff, rxd_d_ff, rx_end, rx_final, m0_final, accept, rx_load;
    logic [7:0] rx_data;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
            rxd_d_ff <= 1'b1;
        end else begin
            rxd_s1_ff <= rxd_i;
            rxd_s2_ff <= rxd_s1_ff;
            rxd_d_ff <= rxd_s2_ff;
        end
    end

    assign rx_end = (rx_m0_ff | rx_tick) & (rx_cnt_ff == (rx_m0_ff ? M0_LAST : OVS_LAST));
    assign rx_final = (rx_st_ff == ST_STOP) & (rx_tick & (rx_cnt_ff == OVS_MID));
    assign m0_final = (rx_st_ff == ST_DATA) & rx_m0_ff & rx_end & (rx_bit_ff == BIT_LAST);
    // Extended mode may overwrite; frame check demands a stop bit of 1
    assign accept = (extended_uart_enable_ff | ~serial_control_ff.rx_done_flag)
                    & (~serial_control_ff.frame_check_enable | rxd_s2_ff);
    assign rx_load = m0_final | (rx_final & accept);
    assign rx_data = m0_final ? {rxd_s2_ff, rx_sh_ff[7:1]} : rx_sh_ff;

    // Data bits sampled mid-bit: start checked at tick 7, then every 16
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_st_ff <= ST_IDLE;
            rx_cnt_ff <= '0;
            rx_bit_ff <= '0;
            rx_sh_ff <= '0;
            rx_m0_ff <= 1'b0;
        end else begin
            if (rx_st_ff != ST_IDLE && (rx_m0_ff || rx_tick)) rx_cnt_ff <= rx_cnt_ff + 4'h1;
            unique case (rx_st_ff)
                ST_IDLE: begin
                    rx_cnt_ff <= '0;
                    rx_bit_ff <= '0;
                    if (serial_control_ff.rx_enable && mode == MODE_SHIFT && !serial_control_ff.rx_done_flag
                        && tx_st_ff == ST_IDLE && !tx_go) begin
                        rx_m0_ff <= 1'b1;
                        rx_st_ff <= ST_DATA;
                    end else if (serial_control_ff.rx_enable && mode == MODE_ASYNC8
                                 && rxd_d_ff && !rxd_s2_ff) begin
                        rx_m0_ff <= 1'b0;
                        rx_st_ff <= ST_START;
                    end
                end
                ST_START: begin
                    if (rx_tick && rx_cnt_ff == OVS_MID) begin
                        rx_cnt_ff <= '0;
                        rx_st_ff <= rxd_s2_ff ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx_end) begin
                        rx_cnt_ff <= '0;
                        rx_sh_ff <= {rxd_s2_ff, rx_sh_ff[7:1]};
                        rx_bit_ff <= rx_bit_ff + 3'h1;
                        if (rx_bit_ff == BIT_LAST) rx_st_ff <= rx_m0_ff ? ST_IDLE : ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (rx_final) rx_st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control, buffer and error flags; hardware set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_control_ff <= '0;
            rxbuf_ff <= REG_RST;
        end else begin
            if (wr_serial_control) serial_control_ff <= wbyte_ff;
            if (tx_fin_ff) serial_control_ff.tx_done_flag <= 1'b1;
            if (rx_load) begin
                rxbuf_ff <= rx_data;
                serial_control_ff.rx_done_flag <= 1'b1;
                if (!m0_final) serial_control_ff.received_ninth_bit <= rxd_s2_ff;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            extended_uart_enable_ff <= 1'b0;
            owe_ff <= 1'b0;
            fe_ff <= 1'b0;
        end else begin
            if (wr_cfg) begin
                extended_uart_enable_ff <= wbyte_ff[CFG_EXT_BIT];
                if (!wbyte_ff[CFG_OWE_BIT]) owe_ff <= 1'b0;
            end
            if (rx_final && serial_control_ff.rx_done_flag) owe_ff <= 1'b1;
            if (rx_final) fe_ff <= ~rxd_s2_ff;
        end
    end

    // Interrupt status: rx load, tx done, overwrite; write one to clear
    logic [IST_W-1:0] ist_ev, ist_clr;
    assign ist_ev = {rx_final & serial_control_ff.rx_done_flag, tx_fin_ff, rx_load};
    assign ist_clr = wr_ist ? wbyte_ff[IST_W-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_ff <= '0;
            imask_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            ist_ff <= (ist_ff & ~ist_clr) | ist_ev;
            if (wr_imask) imask_ff <= wbyte_ff[IST_W-1:0];
            irq_ff <= |(ist_ff & imask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins; shift mode clock low for the first half of each 12-cycle bit
    logic txd_ff, rxd_o_ff, rxd_oe_n_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txd_ff <= 1'b1;
            rxd_o_ff <= 1'b1;
            rxd_oe_n_ff <= 1'b1;
        end else begin
            rxd_o_ff <= tx_sh_ff[0];
            rxd_oe_n_ff <= ~((tx_st_ff != ST_IDLE) & tx_m0_ff);
            if (tx_st_ff != ST_IDLE && tx_m0_ff) txd_ff <= (tx_cnt_ff >= M0_HALF);
            else if (rx_st_ff != ST_IDLE && rx_m0_ff) txd_ff <= (rx_cnt_ff >= M0_HALF);
            else if (tx_st_ff == ST_START) txd_ff <= 1'b0;
            else if (tx_st_ff == ST_IDLE) txd_ff <= 1'b1;
            else txd_ff <= tx_sh_ff[0];
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign txd = txd_ff;
    assign rxd_o = rxd_o_ff;
    assign rxd_oe_n = rxd_oe_n_ff;
    assign irq = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_frac_bit6;
        @(posedge aclk) disable iff (!aresetn) wr_frac |=> (frac_ff[6] == 1'b0);
    endproperty
    a_frac_bit6: assert property (p_frac_bit6) else $error("fraction bit 6 stored");

    property p_m0_len;
        @(posedge aclk) disable iff (!aresetn)
            (tx_go && mode == MODE_SHIFT) |-> ##97 tx_fin_ff;
    endproperty
    a_m0_len: assert property (p_m0_len) else $error("shift transfer not 96 cycles");

    property p_m0_drive;
        @(posedge aclk) disable iff (!aresetn)
            (tx_go && mode == MODE_SHIFT) |-> ##2 (!rxd_oe_n && rxd_o == $past(wbyte_ff[0], 2));
    endproperty
    a_m0_drive: assert property (p_m0_drive) else $error("shift data not driven LSB");

    property p_start_bit;
        @(posedge aclk) disable iff (!aresetn)
            (tx_go && mode == MODE_ASYNC8) |-> ##2 !txd;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit");

    property p_tx_done_stop;
        @(posedge aclk) disable iff (!aresetn)
            (tx_done_set && !tx_m0_ff) |-> ##1 tx_fin_ff ##1 (txd && serial_control_ff.tx_done_flag);
    endproperty
    a_tx_done_stop: assert property (p_tx_done_stop) else $error("tx done not at stop");

    property p_reject;
        @(posedge aclk) disable iff (!aresetn)
            (rx_final && !accept && !serial_control_ff.rx_done_flag && !wr_serial_control)
            |=> !serial_control_ff.rx_done_flag;
    endproperty
    a_reject: assert property (p_reject) else $error("rejected frame set rx done");

    property p_accept;
        @(posedge aclk) disable iff (!aresetn)
            (rx_final && accept) |=> (serial_control_ff.rx_done_flag && rxbuf_ff == $past(rx_sh_ff)
                                      && serial_control_ff.received_ninth_bit == $past(rxd_s2_ff));
    endproperty
    a_accept: assert property (p_accept) else $error("accepted frame not loaded");

    property p_owe;
        @(posedge aclk) disable iff (!aresetn)
            (rx_final && serial_control_ff.rx_done_flag) |=> (owe_ff && ist_ff[2]);
    endproperty
    a_owe: assert property (p_owe) else $error("overwrite not flagged");

    property p_fe;
        @(posedge aclk) disable iff (!aresetn) rx_final |=> (fe_ff == !$past(rxd_s2_ff));
    endproperty
    a_fe: assert property (p_fe) else $error("frame error wrong");

    property p_ut_sel;
        @(posedge aclk) disable iff (!aresetn) baud_en |-> (tx_tick == ut_tick && rx_tick == ut_tick);
    endproperty
    a_ut_sel: assert property (p_ut_sel) else $error("baud timer not selected");

    c_m0_tx: cover property (@(posedge aclk) disable iff (!aresetn) tx_go && mode == MODE_SHIFT);
    c_m1_rx: cover property (@(posedge aclk) disable iff (!aresetn) rx_final && accept);
    c_owe: cover property (@(posedge aclk) disable iff (!aresetn) rx_final && extended_uart_enable_ff
                           && serial_control_ff.rx_done_flag);
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench of the serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import usp_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, rxd_o, rxd_oe_n, txd, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [7:0] b, b2;
    logic t1_ovf, t2_ovf;
    wire logic peer_line, rxd_line;
    int fail_count, compares;
    assign rxd_line = rxd_oe_n ? peer_line : rxd_o;
    usp_serial_port u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer1_ovf(t1_ovf), .timer2_ovf(t2_ovf), .rxd_i(rxd_line), .rxd_o(rxd_o),
        .rxd_oe_n(rxd_oe_n), .txd(txd), .irq(irq));
    usp_remote u_peer (.aclk(aclk), .txd(txd), .line(peer_line));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [IW-1:0] i, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (!bvalid) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [IW-1:0] i);
        @(posedge aclk);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Async transmit of one byte, checked at the remote end
    task automatic tx1(input logic [7:0] v);
        wr(IDX_SERIAL_BUFFER, v);
        d = '0;
        for (int n = 0; n < 400 && d[1] !== 1'b1; n++) rd(IDX_SERIAL_CONTROL);
        repeat (40) @(posedge aclk);
        chk(u_peer.got, v);
        chk(u_peer.stp, 1'b1);
        wr(IDX_SERIAL_CONTROL, 8'h50);
    endtask
    task automatic end_sim;
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge aclk);
        fail_count++;
        end_sim;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, t1_ovf, t2_ovf} = 8'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        wstrb = 4'hF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        void'($urandom(31404));
        rd(IDX_FRAC); chk(d, 32'h0);
        wr(IDX_FRAC, 8'hFF); chk(r, RESP_OKAY);
        rd(IDX_FRAC); chk(d, 32'hBF);
        rd(10'h3FF); chk(r, RESP_SLVERR);
        wr(10'h3FF, 8'h01); chk(r, RESP_SLVERR);
        // Dedicated timer, one tick a cycle; timer2 selects set but timers stopped
        wr(IDX_FRAC, 8'h80); wr(IDX_SERIAL_CONTROL, 8'h50); wr(IDX_IMASK, 8'h01);
        wr(IDX_BSRC, 8'hB0);
        for (int k = 0; k < 3; k++) begin
            b = (k == 0) ? 8'hFF : $urandom;
            tx1(b);
        end
        b = $urandom; b2 = ~b;
        u_peer.send(b, 1'b1);
        rd(IDX_SERIAL_CONTROL); chk(d[2:0], 3'h5);
        chk(irq, 1'b1);
        rd(IDX_SERIAL_BUFFER); chk(d, b);
        u_peer.send(b2, 1'b1);
        rd(IDX_SERIAL_BUFFER); chk(d, b);
        rd(IDX_CFG); chk(d[7], 1'b1);
        wr(IDX_CFG, 8'h00); wr(IDX_IST, 8'h07);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        rd(IDX_CFG); chk(d, 32'h0);
        wr(IDX_SERIAL_CONTROL, 8'h70);
        u_peer.send(b, 1'b0);
        rd(IDX_SERIAL_CONTROL); chk(d[0], 1'b0);
        rd(IDX_CFG); chk(d[6], 1'b1);
        wr(IDX_CFG, 8'h01); wr(IDX_SERIAL_CONTROL, 8'h50);
        u_peer.send(b, 1'b1);
        u_peer.send(b2, 1'b1);
        rd(IDX_SERIAL_BUFFER); chk(d, b2);
        // Timer2 then doubled timer1 as bit clock
        wr(IDX_FRAC, 8'h00);
        t2_ovf <= 1'b1;
        b = $urandom;
        tx1(b);
        wr(IDX_BSRC, 8'h80);
        t1_ovf <= 1'b1;
        t2_ovf <= 1'b0;
        b = $urandom;
        tx1(b);
        // Shift register mode: data on rx pin, clock on tx pin
        wr(IDX_SERIAL_CONTROL, 8'h00);
        b = $urandom;
        wr(IDX_SERIAL_BUFFER, b);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            b2[i] = rxd_line;
        end
        chk(rxd_oe_n, 1'b0);
        chk(b2, b);
        repeat (20) @(posedge aclk);
        rd(IDX_SERIAL_CONTROL); chk(d[1], 1'b1);
        chk(rxd_oe_n, 1'b1);
        wr(IDX_SERIAL_CONTROL, 8'h10);
        repeat (120) @(posedge aclk);
        rd(IDX_SERIAL_CONTROL); chk(d[0], 1'b1);
        rd(IDX_SERIAL_BUFFER); chk(d, 32'hFF);
        end_sim;
    end
endmodule
`default_nettype wire

// ===== verification/usp_remote.sv
// Remote serial device on the receive and transmit lines
`timescale 1ns/1ps
`default_nettype none
module usp_remote #(
    parameter int BIT = 16
) (
    input wire logic aclk,
    input wire logic txd,
    output logic line
);
    logic [7:0] got;
    logic stp;
    initial line = 1'b1;
    // Frame: start 0, data LSB first, stop
    task automatic send(input logic [7:0] d, input logic s);
        logic [9:0] f;
        f = {s, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge aclk);
            line <= f[i];
            repeat (BIT - 1) @(posedge aclk);
        end
        @(posedge aclk);
        line <= 1'b1;
    endtask
    // Samples mid bit; stop kept for the bench
    initial forever begin
        @(negedge txd);
        repeat (BIT + BIT / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            got[i] = txd;
            repeat (BIT) @(posedge aclk);
        end
        stp = txd;
    end
endmodule
`default_nettype wire
